// file: hw/otg_link_pkg.sv
package otg_link_pkg;
  // Clock
  localparam int unsigned HCLK_HZ            = 40_000_000;
  // Derived bit clock ratios against the 480 MHz high-speed clock
  localparam int unsigned HS_BIT_HZ          = 480_000_000;
  localparam int unsigned IF_CLK_HZ          = 60_000_000;
  localparam int unsigned FS_BIT_HZ          = 12_000_000;
  localparam int unsigned LS_BIT_HZ          = 1_500_000;
  localparam int unsigned IF_DIV             = HS_BIT_HZ / IF_CLK_HZ;
  localparam int unsigned FS_DIV             = HS_BIT_HZ / FS_BIT_HZ;
  localparam int unsigned LS_DIV             = HS_BIT_HZ / LS_BIT_HZ;
  // Power-on reset stretch, in device clock cycles
  localparam int unsigned POR_CYCLES         = 16;
  // Status byte layout
  localparam int unsigned ST_VBUS_LSB        = 0;
  localparam int unsigned ST_SESS_VALID      = 2;
  localparam int unsigned ST_SESSION_END_FLAG        = 3;
  localparam int unsigned ST_ID_GROUNDED_FLAG          = 4;
  localparam logic [1:0]  VBUS_STATE_GOOD    = 2'h3;
  localparam logic [7:0]  ULPI_CMD_RESET     = 8'hC5;
  localparam logic [7:0]  ULPI_IDLE          = 8'h00;
  // Control byte bit positions (link to device)
  localparam int unsigned CT_ID_SENSE        = 0;
  localparam int unsigned CT_DISCHARGE       = 1;
  localparam int unsigned CT_CHARGE          = 2;
  localparam int unsigned CT_EXT_DRIVE       = 3;
  localparam logic [7:0]  CMD_CTRL_TAG       = 8'h80;
  // AHB register offsets of the link controller
  localparam logic [7:0]  REG_CTRL           = 8'h00;
  localparam logic [7:0]  REG_STATUS         = 8'h04;
  localparam logic [7:0]  REG_SRP            = 8'h08;
  localparam int unsigned CR_ID_SENSE        = 0;
  localparam int unsigned CR_HOST_DRIVE      = 1;
  localparam int unsigned CR_SRP_START       = 0;
  localparam logic [31:0] CTRL_RESET_VALUE   = 32'h0000_0000;
endpackage : otg_link_pkg

// file: hw/ulpi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ulpi_if;
  logic       dir;       // Device owns the data bus
  logic       nxt;       // Device next strobe
  logic       stp;       // Link stop
  logic [7:0] data_dev;  // Data driven by device
  logic [7:0] data_lnk;  // Data driven by link
  logic       dev_oe_n;  // Device output enable, low drives
  logic       lnk_oe_n;  // Link output enable, low drives
  logic       clk_if;    // Interface clock strobe from device
  modport device (output dir, output nxt, output data_dev, output dev_oe_n,
                  output clk_if, input stp, input data_lnk, input lnk_oe_n);
  modport link   (input dir, input nxt, input data_dev, input dev_oe_n,
                  input clk_if, output stp, output data_lnk, output lnk_oe_n);
endinterface : ulpi_if
`default_nettype wire

// file: hw/clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
module clk_divider #(
  parameter int unsigned DIV = 8
) (
  input  wire logic hclk,     // Clock
  input  wire logic hresetn,  // Async reset
  output logic      tick      // One pulse every DIV cycles
);
  logic [15:0] cnt_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == 16'(DIV - 1)) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign tick = (cnt_reg == 16'(DIV - 1));
endmodule : clk_divider
`default_nettype wire

// file: hw/otg_phy_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - ID detection only while sense enable set
// - Report ID change by status update
// - Micro-A reads grounded one, micro-B zero
// - Link picks peripheral on one, host on zero
// - Below valid threshold clears VBUS valid
// - Link ignores VBUS valid during power-up
// - Discharge, await session end, then charge
// - Power-on reset clears all device logic
// - Link sends reset command after clock starts
// - Link holds data low while bus idle
// - Derive interface and bit clock strobes
// - Host drops external drive unless state 11
module otg_phy_ctrl
  import otg_link_pkg::*;
(
  input  wire logic hclk,          // Clock
  input  wire logic hresetn,       // Async reset, active low
  ulpi_if.device    ulpi,          // Bus to link
  input  wire logic id_pin,        // Sampled ID pin, high is floating
  input  wire logic vbus_valid_in, // Valid comparator
  input  wire logic sess_valid_in, // Session valid comparator
  input  wire logic session_end_flag_in,   // Session end comparator
  output logic      id_sense_enable_on,  // ID pull-up enable
  output logic      discharge_on,  // VBUS discharge resistor
  output logic      charge_on,     // VBUS charge resistor
  output logic      ext_drive_n,   // Power switch, low enables
  output logic      fs_tick,       // Full-speed bit strobe
  output logic      ls_tick        // Low-speed bit strobe
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {ST_POR, ST_IDLE, ST_STATUS, ST_WRITE} dev_state_t;
  dev_state_t  state_reg;
  logic [7:0]  por_cnt_reg;
  logic [3:0]  ctrl_reg;
  logic [7:0]  reported_reg;
  logic [7:0]  status_now;
  logic        if_tick;
  logic        id_grounded_flag;
  logic        vbus_ok;
  logic        cmd_ctrl;
  logic        cmd_reset;

  clk_divider #(.DIV(IF_DIV)) u_if (.hclk(hclk), .hresetn(hresetn),
                                    .tick(if_tick));
  clk_divider #(.DIV(FS_DIV)) u_fs (.hclk(hclk), .hresetn(hresetn),
                                    .tick(fs_tick));
  clk_divider #(.DIV(LS_DIV)) u_ls (.hclk(hclk), .hresetn(hresetn),
                                    .tick(ls_tick));
  assign ulpi.clk_if = if_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Status byte
  assign id_grounded_flag = ctrl_reg[CT_ID_SENSE] ? ~id_pin
                                                  : reported_reg[ST_ID_GROUNDED_FLAG];
  assign vbus_ok = vbus_valid_in;
  always_comb begin
    status_now = 8'h00;
    status_now[ST_VBUS_LSB +: 2] = vbus_ok ? VBUS_STATE_GOOD
                                : {1'b0, sess_valid_in};
    status_now[ST_SESS_VALID] = sess_valid_in;
    status_now[ST_SESSION_END_FLAG]   = session_end_flag_in;
    status_now[ST_ID_GROUNDED_FLAG]     = id_grounded_flag;
  end

  assign cmd_ctrl  = (state_reg == ST_IDLE) && ulpi.lnk_oe_n == 1'b0 &&
                     (ulpi.data_lnk[7:4] == CMD_CTRL_TAG[7:4]);
  assign cmd_reset = ulpi.lnk_oe_n == 1'b0 && ulpi.data_lnk == ULPI_CMD_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Power-on reset stretch and bus state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_cnt_reg <= 8'h00;
      state_reg   <= ST_POR;
    end else begin
      unique case (state_reg)
        ST_POR: begin
          if (por_cnt_reg == 8'(POR_CYCLES - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            por_cnt_reg <= por_cnt_reg + 8'h01;
          end
        end
        ST_IDLE: begin
          if (cmd_reset) begin
            state_reg <= ST_IDLE;
          end else if (cmd_ctrl) begin
            state_reg <= ST_WRITE;
          end else if (status_now != reported_reg) begin
            state_reg <= ST_STATUS;
          end
        end
        ST_STATUS: state_reg <= ST_IDLE;
        ST_WRITE:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // Last reported copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reported_reg <= 8'h00;
    end else if (state_reg == ST_IDLE && !cmd_ctrl && !cmd_reset &&
                 status_now != reported_reg) begin
      reported_reg <= status_now;
    end
  end

  // Control bits from link; reset command clears them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 4'h0;
    end else if (cmd_reset) begin
      ctrl_reg <= 4'h0;
    end else if (cmd_ctrl) begin
      ctrl_reg <= ulpi.data_lnk[3:0];
    end
  end

  // Bus outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ulpi.data_dev <= ULPI_IDLE;
    end else if (state_reg == ST_IDLE && !cmd_ctrl && !cmd_reset &&
                 status_now != reported_reg) begin
      ulpi.data_dev <= status_now;
    end else begin
      ulpi.data_dev <= ULPI_IDLE;
    end
  end
  assign ulpi.dir      = (state_reg == ST_POR) || (state_reg == ST_STATUS);
  assign ulpi.dev_oe_n = ~ulpi.dir;
  assign ulpi.nxt      = (state_reg == ST_WRITE);

  assign id_sense_enable_on = ctrl_reg[CT_ID_SENSE];
  assign discharge_on = ctrl_reg[CT_DISCHARGE];
  assign charge_on    = ctrl_reg[CT_CHARGE];
  assign ext_drive_n  = ~ctrl_reg[CT_EXT_DRIVE];
endmodule : otg_phy_ctrl
`default_nettype wire

// file: hw/otg_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module otg_link_ctrl
  import otg_link_pkg::*;
(
  input  wire logic        hclk,      // Clock
  input  wire logic        hresetn,   // Async reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write
  input  wire logic [2:0]  hsize,     // Size
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic      [31:0] hrdata,    // Read data
  output logic             hreadyout, // Slave ready
  output logic             hresp,     // Response, always OKAY
  ulpi_if.link             ulpi       // Bus to device
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum {L_RESET, L_IDLE, L_SEND, L_DISCH, L_CHRG} link_state_t;
  link_state_t state_reg;
  logic [7:0]  status_reg;
  logic [1:0]  ctrl_reg;
  logic        srp_req_reg;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic        clk_seen_reg;
  logic        discharge_bit;
  logic        charge_bit;
  logic        host_mode;
  logic        ext_drive;
  logic [7:0]  tx_byte;
  logic        phase_ok;
  logic [7:0]  lnk_data_reg;

  assign phase_ok  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // AHB write capture and register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= phase_ok && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET_VALUE[1:0];
    end else if (wr_pend_reg && wr_addr_reg == REG_CTRL) begin
      ctrl_reg <= hwdata[1:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (phase_ok && !hwrite) begin
      unique case (haddr[7:0])
        REG_CTRL:   hrdata <= {30'h0, ctrl_reg};
        REG_STATUS: hrdata <= {24'h0, status_reg};
        REG_SRP:    hrdata <= {29'h0, state_reg == L_CHRG,
                               state_reg == L_DISCH, srp_req_reg};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status capture from device
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= 8'h00;
    end else if (ulpi.dir && !ulpi.dev_oe_n) begin
      status_reg <= ulpi.data_dev;
    end
  end
  // Role from grounded flag: one peripheral, zero host
  assign host_mode = ~status_reg[ST_ID_GROUNDED_FLAG];
  // VBUS valid used only after start-up reset command
  assign ext_drive = ctrl_reg[CR_HOST_DRIVE] && host_mode &&
                     state_reg != L_RESET &&
                     status_reg[ST_VBUS_LSB +: 2] == VBUS_STATE_GOOD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srp_req_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == REG_SRP &&
                 hwdata[CR_SRP_START]) begin
      srp_req_reg <= 1'b1;
    end else if (state_reg == L_CHRG) begin
      srp_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_seen_reg <= 1'b0;
    end else if (ulpi.clk_if) begin
      clk_seen_reg <= 1'b1;
    end
  end

  // SRP and command sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= L_RESET;
    end else begin
      unique case (state_reg)
        L_RESET: if (clk_seen_reg && !ulpi.dir) state_reg <= L_IDLE;
        L_IDLE: begin
          // Reset command cut off by a status turnaround: send it again
          if (ulpi.dir && lnk_data_reg == ULPI_CMD_RESET) begin
            state_reg <= L_RESET;
          end else if (srp_req_reg && !ulpi.dir) begin
            state_reg <= L_DISCH;
          end
        end
        L_DISCH: if (status_reg[ST_SESSION_END_FLAG]) state_reg <= L_CHRG;
        L_CHRG:  state_reg <= L_IDLE;
        default: state_reg <= L_IDLE;
      endcase
    end
  end
  assign discharge_bit = (state_reg == L_DISCH);
  assign charge_bit    = (state_reg == L_CHRG);

  always_comb begin
    tx_byte = CMD_CTRL_TAG;
    tx_byte[CT_ID_SENSE]  = ctrl_reg[CR_ID_SENSE];
    tx_byte[CT_DISCHARGE] = discharge_bit;
    tx_byte[CT_CHARGE]    = charge_bit;
    tx_byte[CT_EXT_DRIVE] = ext_drive;
  end

  // Control byte resent when it changes; reset command sent from L_RESET; bus low otherwise
  logic [7:0] sent_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lnk_data_reg <= ULPI_IDLE;
      sent_reg     <= 8'h00;
    end else if (ulpi.dir) begin
      lnk_data_reg <= ULPI_IDLE;
      // Byte lost to the device taking the bus: force a resend
      if (lnk_data_reg != ULPI_IDLE) begin
        sent_reg <= 8'h00;
      end
    end else if (state_reg == L_RESET && clk_seen_reg) begin
      lnk_data_reg <= ULPI_CMD_RESET;
    end else if (state_reg != L_RESET && tx_byte != sent_reg &&
                 lnk_data_reg == ULPI_IDLE) begin
      lnk_data_reg <= tx_byte;
      sent_reg     <= tx_byte;
    end else begin
      lnk_data_reg <= ULPI_IDLE;
    end
  end
  // Bus shows low whenever the device owns it
  assign ulpi.data_lnk = ulpi.dir ? ULPI_IDLE : lnk_data_reg;
  assign ulpi.lnk_oe_n = ulpi.dir;
  assign ulpi.stp      = 1'b0;
endmodule : otg_link_ctrl
`default_nettype wire

// file: dv/otg_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module otg_link_props
  import otg_link_pkg::*;
(
  input wire logic       hclk,     // Clock
  input wire logic       hresetn,  // Async reset, active low
  input wire logic       dir,      // Device owns bus
  input wire logic       nxt,      // Device next strobe
  input wire logic [7:0] data_lnk, // Link data
  input wire logic       dev_oe_n, // Device enable, low drives
  input wire logic       lnk_oe_n, // Link enable, low drives
  input wire logic       clk_if    // Interface clock strobe
);
  logic [4:0] por_cnt_reg;
  logic       clk_seen_reg;
  logic       cmd_seen_reg;
  logic       up;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) por_cnt_reg <= 5'h00;
    else if (por_cnt_reg != 5'h1F) por_cnt_reg <= por_cnt_reg + 5'h01;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) clk_seen_reg <= 1'b0;
    else if (clk_if) clk_seen_reg <= 1'b1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_seen_reg <= 1'b0;
    else if (data_lnk != ULPI_IDLE) cmd_seen_reg <= 1'b1;
  end
  assign up = (por_cnt_reg == 5'h1F);

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_por_block: assert property (por_cnt_reg < 5'h0E |-> dir)
    else $error("bus not blocked during power-on reset");
  a_quiet_start: assert property (!clk_seen_reg |-> data_lnk == ULPI_IDLE)
    else $error("link data before interface clock");
  a_first_reset: assert property (!cmd_seen_reg && data_lnk != ULPI_IDLE
    |-> data_lnk == ULPI_CMD_RESET)
    else $error("first link byte is not the reset command");
  a_idle_enable: assert property (data_lnk != ULPI_IDLE |-> !lnk_oe_n)
    else $error("nonzero link data while not driving");
  a_no_clash: assert property (dev_oe_n || lnk_oe_n)
    else $error("both ends drive the data bus");
  a_ifclk_period: assert property (clk_if |=> !clk_if [*7] ##1 clk_if)
    else $error("interface clock strobe spacing wrong");
  a_status_pulse: assert property (up && $rose(dir) |=> !dir)
    else $error("status update longer than one cycle");
  a_ctrl_next: assert property (up && !dir && !lnk_oe_n
    && data_lnk[7:4] == 4'h8 |=> nxt)
    else $error("control byte not acknowledged");
endmodule : otg_link_props
`default_nettype wire

// file: dv/tb_otg_id_vbus_session_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_otg_id_vbus_session_control;
  import otg_link_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        id_pin, vbus_valid_in, sess_valid_in, session_end_flag_in;
  logic        id_sense_enable_on, discharge_on, charge_on, ext_drive_n;
  logic        fs_tick, ls_tick;
  int          err_count, checks_done;

  ulpi_if ulpi_if_i();
  otg_phy_ctrl otg_phy_ctrl_i(.hclk, .hresetn, .ulpi(ulpi_if_i), .id_pin,
    .vbus_valid_in, .sess_valid_in, .session_end_flag_in, .id_sense_enable_on,
    .discharge_on, .charge_on, .ext_drive_n, .fs_tick, .ls_tick);
  otg_link_ctrl otg_link_ctrl_i(.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp(), .ulpi(ulpi_if_i));
  otg_link_props otg_link_props_i(.hclk, .hresetn, .dir(ulpi_if_i.dir),
    .nxt(ulpi_if_i.nxt), .data_lnk(ulpi_if_i.data_lnk),
    .dev_oe_n(ulpi_if_i.dev_oe_n), .lnk_oe_n(ulpi_if_i.lnk_oe_n),
    .clk_if(ulpi_if_i.clk_if));

  always #12.5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Bounded wait for a level, sampled as it stood before each edge
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v) begin
      n++;
      if (n > 400) begin
        err_count++;
        stop_test();
      end
      @(posedge hclk);
    end
  endtask : wait_lvl

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    wait_lvl(hreadyout, 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    wait_lvl(hreadyout, 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic poll(input logic [7:0] a, input logic [31:0] m, e,
                      output logic [31:0] rd);
    for (int n = 0; n < 80; n++) begin
      ahb(1'b0, a, 32'h0, rd);
      if ((rd & m) === e) break;
    end
  endtask : poll

  // Level 0 below session end, 3 valid
  task automatic set_lvl(input int l);
    session_end_flag_in   <= (l == 0);
    sess_valid_in <= (l >= 2);
    vbus_valid_in <= (l == 3);
  endtask : set_lvl

  function automatic logic [31:0] exp_status(input logic idp, input int l);
    return {27'h0, !idp, l == 0, l >= 2,
            (l == 3) ? 2'h3 : {1'b0, l >= 2}};
  endfunction : exp_status

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (POR_CYCLES + 4 * IF_DIV) @(posedge hclk);
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd, s0;
    logic        idp;
    int          l, nf, nl;
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    id_pin = 1;
    session_end_flag_in = 1;
    sess_valid_in = 0;
    vbus_valid_in = 0;
    void'($urandom(67));
    do_reset();
    for (int r = 0; r < 2; r++) begin
      ahb(1'b0, REG_CTRL, 32'h0, rd);
      check(rd, CTRL_RESET_VALUE, "ctrl");
      check({id_sense_enable_on, discharge_on, charge_on, ext_drive_n}, 4'h1,
            "pins");
      ahb(1'b1, REG_CTRL, 32'h1, rd);
      do_reset();
    end
    ahb(1'b0, REG_STATUS, 32'h0, s0);
    id_pin <= 1'b0;
    repeat (8 * IF_DIV) @(posedge hclk);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    check(rd & 32'h10, s0 & 32'h10, "id_unsensed");
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    wait_lvl(id_sense_enable_on, 1'b1);
    check(id_sense_enable_on, 1'b1, "id_sense_enable");
    for (int i = 0; i < 14; i++) begin
      idp = (i < 4) ? i[0] : 1'($urandom_range(1, 0));
      l = (i < 4) ? i : $urandom_range(3, 0);
      id_pin <= idp;
      set_lvl(l);
      poll(REG_STATUS, 32'h1F, exp_status(idp, l), rd);
      check(rd & 32'h1F, exp_status(idp, l), "status");
      check(rd[ST_ID_GROUNDED_FLAG], !idp, "id_grounded");
      check(rd[1:0], exp_status(idp, l) & 32'h3, "vbus_state");
    end
    id_pin <= 1'b1;
    set_lvl(3);
    ahb(1'b1, REG_CTRL, 32'h3, rd);
    wait_lvl(ext_drive_n, 1'b0);
    check(ext_drive_n, 1'b0, "ext_on");
    set_lvl(2);
    wait_lvl(ext_drive_n, 1'b1);
    check(ext_drive_n, 1'b1, "ext_off");
    ahb(1'b1, REG_CTRL, 32'h1, rd);
    set_lvl(1);
    ahb(1'b1, REG_SRP, 32'h1, rd);
    wait_lvl(discharge_on, 1'b1);
    repeat (20) begin
      @(posedge hclk);
      check(charge_on, 1'b0, "early_charge");
    end
    ahb(1'b0, REG_SRP, 32'h0, rd);
    check(rd & 32'h7, 32'h3, "srp_discharging");
    set_lvl(0);
    wait_lvl(charge_on, 1'b1);
    poll(REG_SRP, 32'h7, 32'h0, rd);
    check(rd & 32'h7, 32'h0, "srp_done");
    ahb(1'b1, 8'h0C, $urandom, rd);
    ahb(1'b0, 8'h0C, 32'h0, rd);
    check(rd, 32'h0, "unmapped");
    nf = 0;
    nl = 0;
    repeat (2 * LS_DIV) begin
      @(posedge hclk);
      nf += int'(fs_tick === 1'b1);
      nl += int'(ls_tick === 1'b1);
    end
    check(nf, 2 * LS_DIV / FS_DIV, "fs_ticks");
    check(nl, 2, "ls_ticks");
    stop_test();
  end
endmodule : tb_otg_id_vbus_session_control
`default_nettype wire
